// file: design/sild_pkg.sv
// Package for the serial-in latched driver: widths, reset values, sync depth.
// Assumes one 100 MHz clock; pins arrive asynchronously and are synchronised.
// Operation
// - Sample serial data into first stage on each rising serial clock edge.
// - Each further rising edge moves every bit one stage toward serial output.
// - Serial output shows last stage, allowing devices to be chained.
// - While latch-load is high each latch copies its shift stage.
// - Latches follow while load high, hold while low, despite shifting.
// - Enable high turns all drivers off, keeping latch and shift contents.
// - Enable low drives each output from its latch.
// - Exactly eight shift stages, eight latches, eight drivers.
package sild_pkg;
   localparam int          SILD_STAGES     = 8;
   localparam int          SILD_FIFO_DEPTH = 32;
   localparam int          SILD_SYNC_FLOPS = 3;
   localparam logic [7:0]  SILD_SHIFT_RST  = 8'h00;
   localparam logic [7:0]  SILD_LATCH_RST  = 8'h00;
   localparam logic [7:0]  SILD_DRV_RST    = 8'h00;
   localparam logic [2:0]  SILD_SYNC_RST   = 3'h0;
   localparam real         SILD_CLK_NS     = 10.0;
endpackage

// file: design/sild_stream_if.sv
// Valid/ready stream carrying serial bits between the pin front end, FIFO and shift stages.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface sild_stream_if #(parameter int WIDTH = 1);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// file: design/sild_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes clock enable freezes all state; sync active-high reset.
`timescale 1ns/1ns
module sild_fifo
   import sild_pkg::*;
#(
   parameter int WIDTH = 1,
   parameter int DEPTH = SILD_FIFO_DEPTH
)
(
   // Clock and reset
   input wire logic    clk,
   input wire logic    reset,
   input wire logic    ce,
   // Fill and drain sides
   sild_stream_if.snk  in_s,
   sild_stream_if.src  out_s
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
   logic [AW:0]      cnt_q, cnt_d;
   logic             push, pop;

   // Pointers wrap by overflow, so DEPTH must be a power of two
   assign in_s.ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_s.valid = (cnt_q != '0);
   assign out_s.data  = mem_q[rd_q];

   always_comb
   begin
      push  = in_s.valid & in_s.ready;
      pop   = out_s.valid & out_s.ready;
      wr_d  = push ? wr_q + AW'(1) : wr_q;
      rd_d  = pop ? rd_q + AW'(1) : rd_q;
      cnt_d = cnt_q;
      if (push && !pop)
         cnt_d = cnt_q + (AW+1)'(1);
      else if (pop && !push)
         cnt_d = cnt_q - (AW+1)'(1);
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end
      else if (ce)
      begin
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   // Storage needs no reset; only written words are ever read
   always_ff @(posedge clk)
   begin
      if (ce && push)
         mem_q[wr_q] <= in_s.data;
   end
endmodule

// file: design/sild_top.sv
// Serial-in latched driver: pin synchronisers, bit FIFO, shift stages, latches.
// Assumes pins are asynchronous to clk and far slower (clock period 160 ns).
`timescale 1ns/1ns
module sild_top
   import sild_pkg::*;
#(
   parameter int STAGES = SILD_STAGES,
   parameter int DEPTH  = SILD_FIFO_DEPTH
)
(
   // Clock, reset, enable
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire logic              ce,
   // Serial pins
   input  wire logic              ser_data,
   input  wire logic              ser_clk,
   output logic                   ser_out,
   // Control pins
   input  wire logic              latch_load,
   input  wire logic              out_disable,
   // Drivers and flow status
   output logic [STAGES-1:0]      drv_on,
   output logic                   bit_ready
);
   sild_stream_if #(.WIDTH(1)) bit_in ();
   sild_stream_if #(.WIDTH(1)) bit_out ();

   // Three-flop synchronisers; first flop feeds only the second
   logic [SILD_SYNC_FLOPS-1:0] sd_q, sd_d, sc_q, sc_d, ll_q, ll_d, od_q, od_d;
   logic                       data_f_q, data_f_d, clk_f_q, clk_f_d;
   logic                       load_f_q, load_f_d, dis_f_q, dis_f_d;
   logic                       clk_rise;

   // Glitch filter: take stage three once stages two and three agree
   function automatic logic sync_filter(input logic [SILD_SYNC_FLOPS-1:0] s, input logic prev);
      sync_filter = (s[1] == s[2]) ? s[2] : prev;
   endfunction

   always_comb
   begin
      sd_d = {sd_q[1:0], ser_data};
      sc_d = {sc_q[1:0], ser_clk};
      ll_d = {ll_q[1:0], latch_load};
      od_d = {od_q[1:0], out_disable};
      // A change counts only once stages two and three agree
      data_f_d = sync_filter(sd_q, data_f_q);
      clk_f_d  = sync_filter(sc_q, clk_f_q);
      load_f_d = sync_filter(ll_q, load_f_q);
      dis_f_d  = sync_filter(od_q, dis_f_q);
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         sd_q     <= SILD_SYNC_RST;
         sc_q     <= SILD_SYNC_RST;
         ll_q     <= SILD_SYNC_RST;
         od_q     <= SILD_SYNC_RST;
         data_f_q <= 1'b0;
         clk_f_q  <= 1'b0;
         load_f_q <= 1'b0;
         dis_f_q  <= 1'b0;
      end
      else if (ce)
      begin
         sd_q     <= sd_d;
         sc_q     <= sc_d;
         ll_q     <= ll_d;
         od_q     <= od_d;
         data_f_q <= data_f_d;
         clk_f_q  <= clk_f_d;
         load_f_q <= load_f_d;
         dis_f_q  <= dis_f_d;
      end
   end

   // Data settles well ahead of the clock edge, so its filtered value is valid here
   assign clk_rise     = clk_f_d & ~clk_f_q;
   assign bit_in.valid = clk_rise;
   assign bit_in.data  = data_f_q;
   assign bit_ready    = bit_in.ready;

   sild_fifo #(.WIDTH(1), .DEPTH(DEPTH)) u_fifo
   (
      .clk   (clk),
      .reset (reset),
      .ce    (ce),
      .in_s  (bit_in.snk),
      .out_s (bit_out.src)
   );

   // Shift stages, latches, drivers: eight of each by default
   logic [STAGES-1:0] shift_q, shift_d, latch_q, latch_d, drv_d;
   logic              ser_out_d;

   assign bit_out.ready = 1'b1;

   always_comb
   begin
      shift_d = shift_q;
      if (bit_out.valid)
         shift_d = {shift_q[STAGES-2:0], bit_out.data};
      ser_out_d = shift_d[STAGES-1];
      // Copy only once the FIFO has drained, so the latch sees what the pins shifted
      latch_d = latch_q;
      if (load_f_q && !bit_out.valid)
         latch_d = shift_q;
      // Disable gates drivers only; latch and shift stages untouched
      drv_d = dis_f_q ? '0 : latch_d;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         shift_q <= SILD_SHIFT_RST[STAGES-1:0];
         latch_q <= SILD_LATCH_RST[STAGES-1:0];
         drv_on  <= SILD_DRV_RST[STAGES-1:0];
         ser_out <= 1'b0;
      end
      else if (ce)
      begin
         shift_q <= shift_d;
         latch_q <= latch_d;
         drv_on  <= drv_d;
         ser_out <= ser_out_d;
      end
   end
endmodule

// file: sim/sild_assertions.sv
// Port checker for sild_top.
// Assumes ce high and every pin level held 8 clk or more.
`timescale 1ns/1ns
module sild_assertions
#(parameter int STAGES = 8)
(
   // Clock and reset
   input wire logic              clk,
   input wire logic              reset,
   // Pins
   input wire logic              ser_data,
   input wire logic              ser_clk,
   input wire logic              ser_out,
   input wire logic              latch_load,
   input wire logic              out_disable,
   input wire logic [STAGES-1:0] drv_on,
   input wire logic              bit_ready
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_entry;
      $rose(ser_clk) ##0 (ser_clk && latch_load && !out_disable && $stable(ser_data))[*8];
   endsequence
   sequence s_live;
      (latch_load && !out_disable)[*8];
   endsequence
   property p_first; s_entry |-> drv_on[0] == ser_data; endproperty
   a_first: assert property (p_first) else $error("first stage missed data");
   property p_shift;
      s_live ##1 (latch_load && !out_disable && $changed(drv_on)) |-> {drv_on[STAGES-1:1], 1'b0} == ($past(drv_on) << 1);
   endproperty
   a_shift: assert property (p_shift) else $error("drivers did not shift");
   property p_chain; (latch_load && !out_disable && $stable(ser_clk))[*8] |-> ser_out == drv_on[STAGES-1]; endproperty
   a_chain: assert property (p_chain) else $error("serial out not last stage");
   property p_quiet; $stable(ser_clk)[*8] |=> $stable(ser_out); endproperty
   a_quiet: assert property (p_quiet) else $error("serial out moved without clock");
   property p_hold; (!latch_load && $stable(out_disable))[*8] |=> $stable(drv_on); endproperty
   a_hold: assert property (p_hold) else $error("drivers moved with load low");
   property p_off; out_disable[*8] |-> drv_on == '0; endproperty
   a_off: assert property (p_off) else $error("driver on while disabled");
   property p_rst; disable iff (1'b0) reset |=> drv_on == '0 && !ser_out; endproperty
   a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
   property p_room; !ser_clk |-> bit_ready; endproperty
   a_room: assert property (p_room) else $error("bit buffer full");
endmodule

// file: sim/sild_ctrl_model.sv
// Serial controller model: drives data and shift clock pins.
// Assumes each byte starts just after a rising clk edge.
`timescale 1ns/1ns
module sild_ctrl_model
(
   // Serial pins
   output logic ser_data,
   output logic ser_clk
);
   initial
   begin
      ser_data = 1'b0;
      ser_clk = 1'b0;
   end
   // Newest bit last, so the first bit ends in the last stage
   task automatic send(input logic [7:0] v, input int half);
      for (int b = 7; b >= 0; b--)
      begin
         ser_data = v[b];
         #(half);
         ser_clk = 1'b1;
         #(half);
         ser_clk = 1'b0;
      end
      ser_data = ~v[0]; // Stale level must not look valid
   endtask
endmodule

// file: sim/sild_top_tb_top.sv
// Bench for sild_top: controller model, queued expectations.
// Assumes the checker bound below; ce held high.
`timescale 1ns/1ns
module sild_top_tb_top;
   logic       clk = 0, reset = 1, latch_load = 0, out_disable = 0;
   logic       ser_data, ser_clk, ser_out, bit_ready;
   logic [7:0] drv_on, v, held;
   logic [8:0] exp_q[$];
   int         mismatches = 0, check_count = 0;
   always #5 clk = ~clk;
   sild_ctrl_model m (.ser_data(ser_data), .ser_clk(ser_clk));
   sild_top DUT (.clk(clk), .reset(reset), .ce(1'b1), .ser_data(ser_data), .ser_clk(ser_clk),
      .ser_out(ser_out), .latch_load(latch_load), .out_disable(out_disable), .drv_on(drv_on),
      .bit_ready(bit_ready));
   task automatic expect_out(input logic [8:0] e);
      repeat (12) @(posedge clk);
      #1 exp_q.push_back(e);
   endtask
   task automatic end_of_test;
      if (exp_q.size() != 0)
      begin
         mismatches++;
         $display("BAD queue exp 0 got %0d", exp_q.size());
      end
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge clk)
      if (exp_q.size() > 0)
      begin
         check_count++;
         if ({ser_out, drv_on} !== exp_q[0])
         begin
            mismatches++;
            $display("BAD outputs exp %h got %h", exp_q[0], {ser_out, drv_on});
         end
         if (bit_ready !== 1'b1)
         begin
            mismatches++;
            $display("BAD bit_ready exp 1 got %b", bit_ready);
         end
         void'(exp_q.pop_front());
      end
   initial
   begin
      void'($urandom(32'hCCEC));
      repeat (8) @(posedge clk);
      #1 reset = 0;
      held = 8'h00;
      expect_out({1'b0, held});
      for (int i = 0; i < 4; i++)
      begin
         v = 8'($urandom);
         latch_load = i[1];
         out_disable = (i == 2);
         m.send(v, 80);
         if (i[1])
            held = v;
         expect_out({v[7], out_disable ? 8'h00 : held});
         out_disable = 0;
         latch_load = 1;
         held = v;
         expect_out({v[7], v});
         latch_load = 0;
         out_disable = 1;
         expect_out({v[7], 8'h00});
         out_disable = 0;
         expect_out({v[7], v});
      end
      repeat (2) @(posedge clk);
      end_of_test;
   end
endmodule
bind sild_top sild_assertions #(.STAGES(STAGES)) u_chk (.clk(clk), .reset(reset), .ser_data(ser_data),
   .ser_clk(ser_clk), .ser_out(ser_out), .latch_load(latch_load), .out_disable(out_disable),
   .drv_on(drv_on), .bit_ready(bit_ready));
